// File: logic/sepc_pkg.sv
package sepc_pkg;

  // ------------------------------------------------------------------
  // Frame layout
  // ------------------------------------------------------------------
  localparam int ADDR_W8     = 11;
  localparam int ADDR_W16    = 10;
  localparam int DATA_W8     = 8;
  localparam int DATA_W16    = 16;
  localparam int HDR_BITS    = 3;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] OP_SPEC  = 2'h0;
  localparam logic [1:0] SUB_EN   = 2'h3;
  localparam logic [1:0] SUB_BCLR = 2'h2;
  localparam logic [1:0] SUB_BPRG = 2'h1;
  localparam logic [1:0] SUB_DIS  = 2'h0;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ           = 20_000_000;
  localparam int MIN_DESELECT_NS  = 250;
  localparam int MIN_DESELECT_CYC =
    (MIN_DESELECT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PROGRAM_CYCLE_US = 10_000;
  localparam int PROGRAM_CYCLE_CYC =
    PROGRAM_CYCLE_US * (CLK_HZ / 1_000_000);
  localparam logic PROG_EN_RESET  = 1'b0;

  typedef enum logic [2:0] {
    SEPC_IDLE, SEPC_HDR, SEPC_ADDR, SEPC_DATA, SEPC_READ, SEPC_DONE
  } sepc_state_e;

endpackage

// File: logic/sepc_sync.sv
`timescale 1ns/1ps
module sepc_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  logic [W-1:0] meta_q;

  // Meta stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// File: logic/sepc_port.sv
`timescale 1ns/1ps
// Contract
// - Frame opens on select rise, then start bit 1, opcode, address.
// - Opcode 10 read, 01 write with data, 11 erase, 00 special.
// - Address 11 bits byte mode, 10 word mode; data 8 or 16.
// - Special with top bits 11 enables programming.
// - Special top bits 10 erases whole array if enabled.
// - Special top bits 01 plus data writes all locations if enabled.
// - Special top bits 00 disables programming.
// - Read sends one zero dummy bit then word, MSB first.
// - Output changes only on shift clock rising edges in reads.
// - Held select streams next address without dummy bit.
// - Power-up is disabled; writes ignored until enabled.
// - Enable persists until disable or power loss.
// - Erase sets word to ones; timer starts after address.
// - Write timer starts right after last data bit.
// - Select raised after 250ns low shows busy low, ready high.
// - Select raised after cycle end shows no status.
// - Bulk erase uses one timed cycle with status polling.
// - Bulk write stores data into every location.
// - Reads work whether programming enabled or not.
module sepc_port
  import sepc_pkg::*;
#(
  parameter int PROG_CYC = PROGRAM_CYCLE_CYC,
  parameter int DEPTH    = 2048
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Serial link pins
  input  wire logic select_pin,
  input  wire logic shift_clock_pin,
  input  wire logic serial_in_pin,
  input  wire logic organization_pin,
  output logic      serial_out_pin,
  output logic      serial_out_oe,
  // Status
  output logic      program_enabled,
  output logic      program_busy
);

  // ------------------------------------------------------------------
  // Pin synchronisation and edge finding
  // ------------------------------------------------------------------
  logic [3:0] pin_s;
  logic       sel_q, sck_q;

  sepc_sync #(.W(4)) sepc_sync_inst (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .d       ({select_pin, shift_clock_pin, serial_in_pin,
               organization_pin}),
    .q       (pin_s)
  );

  wire sel_s   = pin_s[3];
  wire sck_s   = pin_s[2];
  wire din_s   = pin_s[1];
  wire org_s   = pin_s[0];
  wire sel_r   = sel_s & ~sel_q;
  wire sck_r   = sck_s & ~sck_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sel_q <= 1'b0;
      sck_q <= 1'b0;
    end else begin
      sel_q <= sel_s;
      sck_q <= sck_s;
    end
  end

  // ------------------------------------------------------------------
  // Array: byte lanes, word mode pairs even/odd bytes
  // ------------------------------------------------------------------
  logic [7:0] mem [DEPTH];

  // ------------------------------------------------------------------
  // Frame state
  // ------------------------------------------------------------------
  sepc_state_e st_q;
  logic [4:0]  cnt_q;
  logic [1:0]  op_q;
  logic [10:0] addr_q;
  logic [15:0] sh_q;
  logic        word_q;
  logic        en_q;
  logic [31:0] tmr_q;
  logic [7:0]  low_q;
  logic        low_ok_q;
  logic        stat_q;
  logic [2:0]  job_q;

  // Widths picked at frame start from the organization strap
  wire [4:0] aw = word_q ? 5'(ADDR_W16) : 5'(ADDR_W8);
  wire [4:0] dw = word_q ? 5'(DATA_W16) : 5'(DATA_W8);
  wire [10:0] base = word_q ? {addr_q[9:0], 1'b0} : addr_q;
  wire busy = (tmr_q != 32'h0);
  wire [10:0] a_next = {sh_q[9:0], din_s};
  // Taken from the bit arriving now: addr_q only loads on this same edge
  wire [1:0] sub = word_q ? a_next[9:8] : a_next[10:9];
  wire [10:0] nbase = word_q ? {a_next[9:0], 1'b0} : a_next;
  wire [15:0] d_next = {sh_q[14:0], din_s};
  wire [15:0] rd_word = word_q ? {mem[base], mem[base + 11'h001]}
                               : {8'h00, mem[base]};

  // Job codes launched when a frame completes
  localparam logic [2:0] J_NONE = 3'h0;
  localparam logic [2:0] J_WR   = 3'h1;
  localparam logic [2:0] J_ER   = 3'h2;
  localparam logic [2:0] J_BCLR = 3'h3;
  localparam logic [2:0] J_BPRG = 3'h4;

  logic [15:0] wdata_q;
  logic        launch;
  logic [2:0]  launch_job;
  logic [15:0] launch_data;

  always_comb begin
    launch      = 1'b0;
    launch_job  = J_NONE;
    launch_data = 16'h0000;
    if (sel_s && sck_r && !busy) begin
      if (st_q == SEPC_ADDR && cnt_q == aw - 5'h01) begin
        if (op_q == OP_ERASE && en_q) begin
          launch     = 1'b1;
          launch_job = J_ER;
        end else if (op_q == OP_SPEC && sub == SUB_BCLR && en_q) begin
          launch     = 1'b1;
          launch_job = J_BCLR;
        end
      end else if (st_q == SEPC_DATA && cnt_q == dw - 5'h01 && en_q) begin
        launch      = 1'b1;
        launch_job  = (op_q == OP_WRITE) ? J_WR : J_BPRG;
        launch_data = word_q ? d_next : {8'h00, d_next[7:0]};
      end
    end
  end

  // ------------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q   <= SEPC_IDLE;
      cnt_q  <= 5'h00;
      op_q   <= 2'h0;
      addr_q <= 11'h000;
      sh_q   <= 16'h0000;
      word_q <= 1'b0;
      en_q   <= PROG_EN_RESET;
    end else if (!sel_s) begin
      st_q <= SEPC_IDLE;
    end else if (sel_r) begin
      st_q   <= SEPC_HDR;
      cnt_q  <= 5'h00;
      word_q <= org_s;
    end else if (sck_r) begin
      unique case (st_q)
        SEPC_IDLE, SEPC_DONE: ;
        SEPC_HDR: begin
          // Leading zeros before the start bit are skipped
          if (cnt_q == 5'h00) begin
            if (din_s) cnt_q <= 5'h01;
          end else begin
            op_q  <= {op_q[0], din_s};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'(HDR_BITS - 1)) begin
              st_q  <= SEPC_ADDR;
              cnt_q <= 5'h00;
              sh_q  <= 16'h0000;
            end
          end
        end
        SEPC_ADDR: begin
          sh_q  <= {sh_q[14:0], din_s};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == aw - 5'h01) begin
            addr_q <= a_next;
            cnt_q  <= 5'h00;
            unique case (op_q)
              OP_READ:  st_q <= SEPC_READ;
              OP_WRITE: st_q <= SEPC_DATA;
              OP_ERASE: st_q <= SEPC_DONE;
              OP_SPEC: begin
                st_q <= SEPC_DONE;
                unique case (sub)
                  SUB_EN:   en_q <= 1'b1;
                  SUB_DIS:  en_q <= 1'b0;
                  SUB_BPRG: st_q <= SEPC_DATA;
                  SUB_BCLR: ;
                endcase
              end
            endcase
          end
        end
        SEPC_DATA: begin
          sh_q  <= d_next;
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == dw - 5'h01) st_q <= SEPC_DONE;
        end
        SEPC_READ: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == dw) begin
            // Stream on: next word, no dummy bit
            cnt_q  <= 5'h01;
            addr_q <= addr_q + 11'h001;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Self-timed programming
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tmr_q   <= 32'h0;
      job_q   <= J_NONE;
      wdata_q <= 16'h0000;
    end else if (launch) begin
      tmr_q   <= 32'(PROG_CYC);
      job_q   <= launch_job;
      wdata_q <= launch_data;
    end else if (busy) begin
      tmr_q <= tmr_q - 32'h1;
    end
  end

  // Array update lands on the final cycle of the timed write
  logic [10:0] wbase_q;
  logic        wword_q;
  always_ff @(posedge clk_sys) begin
    if (launch) begin
      wbase_q <= (st_q == SEPC_ADDR) ? nbase : base;
      wword_q <= word_q;
    end
    if (tmr_q == 32'h1) begin
      unique case (job_q)
        J_WR, J_ER: begin
          mem[wbase_q] <= (job_q == J_ER) ? 8'hFF
                        : (wword_q ? wdata_q[15:8] : wdata_q[7:0]);
          if (wword_q)
            mem[wbase_q + 11'h001] <= (job_q == J_ER) ? 8'hFF
                                                      : wdata_q[7:0];
        end
        J_BCLR, J_BPRG: begin
          for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= (job_q == J_BCLR) ? 8'hFF
                    : (wword_q ? ((i % 2 == 0) ? wdata_q[15:8]
                                               : wdata_q[7:0])
                               : wdata_q[7:0]);
          end
        end
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Deselect timing and ready/busy window
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      low_q    <= 8'h00;
      low_ok_q <= 1'b0;
      stat_q   <= 1'b0;
    end else begin
      if (sel_s) low_q <= 8'h00;
      else if (low_q != 8'hFF) low_q <= low_q + 8'h01;
      low_ok_q <= !sel_s && (low_q >= 8'(MIN_DESELECT_CYC - 1));
      if (!sel_s)
        stat_q <= 1'b0;
      else if (sel_r && low_ok_q && busy)
        stat_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Output pin: read data changes on shift clock rise only
  // ------------------------------------------------------------------
  wire [4:0] bit_ix = dw - cnt_q;
  wire       rd_bit = (cnt_q == 5'h00) ? 1'b0 : rd_word[bit_ix[3:0]];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      serial_out_pin  <= 1'b1;
      serial_out_oe   <= 1'b0;
      program_enabled <= 1'b0;
      program_busy    <= 1'b0;
    end else begin
      program_enabled <= en_q;
      program_busy    <= busy;
      if (stat_q && sel_s) begin
        serial_out_oe  <= 1'b1;
        serial_out_pin <= !busy;
      end else if (st_q == SEPC_READ && sel_s) begin
        serial_out_oe <= 1'b1;
        if (sck_r) serial_out_pin <= rd_bit;
      end else begin
        serial_out_oe  <= 1'b0;
        serial_out_pin <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_dis_reset;
    @(posedge clk_sys) $rose(reset_n) |-> !en_q;
  endproperty
  a_dis_reset: assert property (p_dis_reset)
    else $error("programming enabled after reset");

  property p_no_prog_disabled;
    @(posedge clk_sys) disable iff (!reset_n) launch |-> en_q;
  endproperty
  a_no_prog_disabled: assert property (p_no_prog_disabled)
    else $error("program cycle while disabled");

  property p_out_stable;
    @(posedge clk_sys) disable iff (!reset_n)
      (st_q == SEPC_READ && sel_s && !sck_r && !stat_q && $past(sel_s))
        |=> $stable(serial_out_pin);
  endproperty
  a_out_stable: assert property (p_out_stable)
    else $error("read output moved off a clock rise");

  property p_busy_len;
    @(posedge clk_sys) disable iff (!reset_n)
      launch |=> busy [*8];
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("program cycle ended too early");

  property p_status_low;
    @(posedge clk_sys) disable iff (!reset_n)
      (stat_q && sel_s && busy) |=> (serial_out_oe && !serial_out_pin);
  endproperty
  a_status_low: assert property (p_status_low)
    else $error("busy not shown low");

  property p_no_late_status;
    @(posedge clk_sys) disable iff (!reset_n)
      (sel_r && !busy) |=> !stat_q;
  endproperty
  a_no_late_status: assert property (p_no_late_status)
    else $error("status shown after cycle end");

  property p_enable_sticks;
    @(posedge clk_sys) disable iff (!reset_n)
      (en_q && !(st_q == SEPC_ADDR && sck_r)) |=> en_q;
  endproperty
  a_enable_sticks: assert property (p_enable_sticks)
    else $error("enable lost without a command");

  property p_dummy_zero;
    @(posedge clk_sys) disable iff (!reset_n)
      (st_q == SEPC_READ && sel_s && sck_r && cnt_q == 5'h00 && !stat_q)
        |=> !serial_out_pin;
  endproperty
  a_dummy_zero: assert property (p_dummy_zero)
    else $error("dummy bit not zero");

endmodule

// File: test/sepc_host.sv
`timescale 1ns/1ps
module sepc_host (
  // Clock
  input  wire logic clk_sys,
  // Link pins toward the device
  output logic      select_pin,
  output logic      shift_clock_pin,
  output logic      serial_in_pin,
  input  wire logic so_line
);
  initial begin
    select_pin = 1'b0;
    shift_clock_pin = 1'b0;
    serial_in_pin = 1'b0;
  end

  // ----------------------------------------------------------------
  // Link primitives
  // ----------------------------------------------------------------
  // One 400 ns shift period; the sample returned is the output that
  // followed the previous rise, taken well clear of its update
  task automatic bit1(input logic b, output logic r);
    @(posedge clk_sys);
    r = so_line;
    serial_in_pin <= b;
    repeat (3) @(posedge clk_sys);
    shift_clock_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    shift_clock_pin <= 1'b0;
  endtask

  task automatic send(input logic [15:0] v, input int n);
    logic r;
    for (int i = n - 1; i >= 0; i--) bit1(v[i], r);
  endtask

  task automatic raise();
    @(posedge clk_sys);
    select_pin <= 1'b1;
  endtask

  task automatic open_frame(input logic [1:0] op, input logic [15:0] a,
                            input int aw);
    raise();
    send({13'h0000, 1'b1, op}, 3);
    send(a, aw);
  endtask

  // Low time of six cycles keeps above the minimum deselect time
  task automatic close_frame();
    @(posedge clk_sys);
    select_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic read_dummy(output logic d);
    logic r;
    bit1(1'b0, r);
    bit1(1'b0, d);
  endtask

  task automatic read_word(input int dw, output logic [15:0] w);
    w = 16'h0000;
    for (int i = dw - 1; i >= 0; i--) bit1(1'b0, w[i]);
  endtask

  // Status poll: select raised after a long enough low time
  task automatic poll(output logic saw_busy, output logic saw_ready);
    raise();
    repeat (6) @(posedge clk_sys);
    saw_busy = (so_line === 1'b0);
    saw_ready = 1'b0;
    for (int i = 0; i < 200 && !saw_ready; i++) begin
      @(posedge clk_sys);
      saw_ready = (so_line === 1'b1);
    end
    close_frame();
  endtask
endmodule

// File: test/serial_eeprom_command_port_bench.sv
`timescale 1ns/1ps
module serial_eeprom_command_port_bench;
  import sepc_pkg::*;

  logic clk_sys;
  logic reset_n;
  logic org_pin;
  logic select_pin;
  logic shift_clock_pin;
  logic serial_in_pin;
  logic serial_out_pin;
  logic serial_out_oe;
  logic program_enabled;
  logic program_busy;
  logic so_line;
  logic so_last_q = 1'b0;
  int   n_fail = 0;
  int   cmp_count = 0;
  int   cyc = 0;
  int   aw = ADDR_W8;
  int   dw = DATA_W8;

  // Released output line shows the inverse of its last driven level
  always @(posedge clk_sys) if (serial_out_oe) so_last_q <= serial_out_pin;
  assign so_line = serial_out_oe ? serial_out_pin : ~so_last_q;

  sepc_port #(.PROG_CYC(60), .DEPTH(2048)) sepc_port_inst (
    .clk_sys          (clk_sys),
    .reset_n          (reset_n),
    .select_pin       (select_pin),
    .shift_clock_pin  (shift_clock_pin),
    .serial_in_pin    (serial_in_pin),
    .organization_pin (org_pin),
    .serial_out_pin   (serial_out_pin),
    .serial_out_oe    (serial_out_oe),
    .program_enabled  (program_enabled),
    .program_busy     (program_busy)
  );

  sepc_host sepc_host_inst (
    .clk_sys         (clk_sys),
    .select_pin      (select_pin),
    .shift_clock_pin (shift_clock_pin),
    .serial_in_pin   (serial_in_pin),
    .so_line         (so_line)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] spec(input logic [1:0] sub);
    return 16'(sub) << (aw - 2);
  endfunction

  task automatic cmd(input logic [1:0] op, input logic [15:0] a,
                     input logic [15:0] d, input int dn);
    sepc_host_inst.open_frame(op, a, aw);
    if (dn > 0) sepc_host_inst.send(d, dn);
    sepc_host_inst.close_frame();
  endtask

  task automatic poll_ok();
    logic b;
    logic r;
    sepc_host_inst.poll(b, r);
    chk(16'(b), 16'h0001);
    chk(16'(r), 16'h0001);
  endtask

  // Reads two words in one frame to cover streaming
  task automatic rd(input logic [15:0] a, input logic [15:0] e0,
                    input logic [15:0] e1);
    logic        d;
    logic [15:0] w;
    sepc_host_inst.open_frame(OP_READ, a, aw);
    sepc_host_inst.read_dummy(d);
    chk(16'(d), 16'h0000);
    sepc_host_inst.read_word(dw, w);
    chk(w, e0);
    sepc_host_inst.read_word(dw, w);
    chk(w, e1);
    sepc_host_inst.close_frame();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_power_up();
    chk(16'(program_enabled), 16'h0000);
    chk(16'(serial_out_oe), 16'h0000);
    cmd(OP_WRITE, 16'h0005, 16'h00A5, dw);
    chk(16'(program_busy), 16'h0000);
    cmd(OP_SPEC, spec(SUB_BCLR), 16'h0000, 0);
    chk(16'(program_busy), 16'h0000);
    $display("t_power_up done");
  endtask

  task automatic t_program_byte();
    cmd(OP_SPEC, spec(SUB_EN), 16'h0000, 0);
    chk(16'(program_enabled), 16'h0001);
    cmd(OP_SPEC, spec(SUB_BCLR), 16'h0000, 0);
    poll_ok();
    cmd(OP_WRITE, 16'h07FE, 16'h003C, dw);
    poll_ok();
    rd(16'h07FE, 16'h003C, 16'h00FF);
    cmd(OP_ERASE, 16'h07FE, 16'h0000, 0);
    poll_ok();
    rd(16'h07FE, 16'h00FF, 16'h00FF);
    chk(16'(program_enabled), 16'h0001);
    cmd(OP_SPEC, spec(SUB_BPRG), 16'h005A, dw);
    poll_ok();
    rd(16'h0000, 16'h005A, 16'h005A);
    $display("t_program_byte done");
  endtask

  task automatic t_word_mode();
    @(posedge clk_sys);
    org_pin <= 1'b1;
    aw = ADDR_W16;
    dw = DATA_W16;
    cmd(OP_WRITE, 16'h0003, 16'h1234, dw);
    poll_ok();
    rd(16'h0003, 16'h1234, 16'h5A5A);
    cmd(OP_WRITE, 16'h0004, 16'hBEEF, dw);
    repeat (100) @(posedge clk_sys);
    sepc_host_inst.raise();
    repeat (6) @(posedge clk_sys);
    chk(16'(serial_out_oe), 16'h0000);
    sepc_host_inst.close_frame();
    $display("t_word_mode done");
  endtask

  task automatic t_disable();
    cmd(OP_SPEC, spec(SUB_DIS), 16'h0000, 0);
    chk(16'(program_enabled), 16'h0000);
    cmd(OP_ERASE, 16'h0004, 16'h0000, 0);
    chk(16'(program_busy), 16'h0000);
    rd(16'h0004, 16'hBEEF, 16'h5A5A);
    $display("t_disable done");
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      conclude();
    end
  end

  initial begin
    reset_n = 1'b0;
    org_pin = 1'b0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_power_up();
    t_program_byte();
    t_word_mode();
    t_disable();
    conclude();
  end
endmodule
